// *** rtl/usb_endpoint_in_control.sv ***
// Purpose: Endpoint enables, indexed IN control registers and IN pipe logic.
// Assumes: Packet engine and FIFO logic sit outside and report over ports.
// Notes: One answer per IN token to an enabled IN endpoint 1-3, given in the cycle after the token.
module usb_endpoint_in_control (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [6:0] ep0_fifo_count,
  input wire logic out_packet_waiting,
  input wire logic [3:1] fifo_data_written,
  input wire logic [3:1] fifo_not_empty,
  input wire logic sof_seen,
  input wire usb_ep_pkg::token_type in_token,
  input wire logic host_ack,
  input wire logic [1:0] ack_ep,
  output usb_ep_pkg::answer_type answer,
  output logic [3:1] in_event,
  output logic [3:1] fifo_flush,
  output logic [3:1] ep_split,
  output logic [3:1] ep_is_in
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] index_sel;
  logic [3:1] ep_on;
  logic [3:1] ready;
  logic [3:1] stage;
  logic [3:1] held;
  logic [3:1] spare;
  logic [3:1] spare_empty;
  logic [3:1] split;
  logic [3:1] direction;
  logic [3:1] underflow;
  logic [3:1] send_stall;
  logic [3:1] stall_sent;
  logic [3:1] double_buf;
  logic [3:1] iso;
  logic [3:1] iso_update;
  logic [3:1] force_toggle;
  logic [3:1] toggle;
  logic [3:1] pending;
  logic [3:1] empty_pkt;
  logic [3:1] event_flag;
  logic [7:0] out_low [3:1];
  logic [7:0] out_high [3:1];
  logic [7:0] next_rdata;
  logic sel_ok;
  logic wr_low;
  logic wr_high;

  assign sel_ok = index_sel != 2'd0;
  assign wr_low = reg_write && sel_ok &&
                  reg_addr == usb_ep_pkg::in_ctrl_status_low_addr;
  assign wr_high = reg_write && sel_ok &&
                   reg_addr == usb_ep_pkg::in_ctrl_status_high_addr;
  assign in_event = event_flag;

  // Packet engine uses these to route each FIFO half.
  assign ep_split = split;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (rst) begin
      index_sel <= 2'd0;
      ep_on <= usb_ep_pkg::enable_reset[3:1];
    end else if (reg_write) begin
      if (reg_addr == usb_ep_pkg::index_select_addr) begin
        index_sel <= reg_wdata[1:0];
      end
      if (reg_addr == usb_ep_pkg::endpoint_enable_bits_addr) begin
        ep_on <= reg_wdata[3:1];
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      usb_ep_pkg::endpoint0_rx_byte_count_addr: begin
        next_rdata = {1'b0, ep0_fifo_count};
      end
      usb_ep_pkg::endpoint_enable_bits_addr: begin
        next_rdata = {usb_ep_pkg::enable_high_ones, ep_on, 1'b1};
      end
      usb_ep_pkg::index_select_addr: begin
        next_rdata = {6'h00, index_sel};
      end
      usb_ep_pkg::in_event_addr: begin
        next_rdata = {4'h0, event_flag, 1'b0};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
    if (sel_ok) begin
      case (reg_addr)
        usb_ep_pkg::in_ctrl_status_low_addr: begin
          // Toggle reset is write-only and reads as zero.
          next_rdata = {1'b0, 1'b0, stall_sent[index_sel],
                        send_stall[index_sel], 1'b0, underflow[index_sel],
                        fifo_not_empty[index_sel], ready[index_sel]};
        end
        usb_ep_pkg::in_ctrl_status_high_addr: begin
          next_rdata = {double_buf[index_sel], iso[index_sel],
                        iso_update[index_sel], split[index_sel],
                        force_toggle[index_sel], direction[index_sel],
                        2'b00};
        end
        usb_ep_pkg::out_ctrl_status_low_addr: begin
          next_rdata = out_low[index_sel];
        end
        usb_ep_pkg::out_ctrl_status_high_addr: begin
          next_rdata = out_high[index_sel];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? next_rdata : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-endpoint IN pipe. A committed packet moves to "pending"; in double
  // buffer mode the ready flag is then free for a second packet.
  genvar e;
  generate
    for (e = 1; e <= 3; e++) begin : g_ep
      logic tok;
      logic ack;
      logic has_pkt;
      logic flush_wr;
      logic ready_wr;
      logic send;
      assign tok = in_token.valid && in_token.ep == e[1:0] && ep_on[e] &&
                   ep_is_in[e];
      assign ack = host_ack && ack_ep == e[1:0];
      assign has_pkt = pending[e] && !held[e];
      assign flush_wr = wr_low && index_sel == e[1:0] &&
                        reg_wdata[usb_ep_pkg::flush_bit];
      assign ready_wr = wr_low && index_sel == e[1:0] &&
                        reg_wdata[usb_ep_pkg::ready_bit];
      assign send = tok && !send_stall[e] && has_pkt;

      always_ff @(posedge mclk) begin
        if (rst) begin
          out_low[e] <= 8'h00;
          out_high[e] <= 8'h00;
        end else if (reg_write && sel_ok && index_sel == e[1:0]) begin
          if (reg_addr == usb_ep_pkg::out_ctrl_status_low_addr) begin
            out_low[e] <= reg_wdata;
          end
          if (reg_addr == usb_ep_pkg::out_ctrl_status_high_addr) begin
            out_high[e] <= reg_wdata;
          end
        end
      end

      // Split lives in bit 4 of the high byte; direction in bit 2.
      always_ff @(posedge mclk) begin
        if (rst) begin
          double_buf[e] <= 1'b0;
          iso[e] <= 1'b0;
          iso_update[e] <= 1'b0;
          force_toggle[e] <= 1'b0;
          split[e] <= 1'b0;
          direction[e] <= 1'b0;
          ep_is_in[e] <= 1'b0;
        end else if (wr_high && index_sel == e[1:0]) begin
          double_buf[e] <= reg_wdata[usb_ep_pkg::double_buffer_bit];
          iso[e] <= reg_wdata[usb_ep_pkg::iso_bit];
          iso_update[e] <= reg_wdata[usb_ep_pkg::iso_update_bit];
          force_toggle[e] <= reg_wdata[usb_ep_pkg::force_toggle_bit];
          split[e] <= reg_wdata[usb_ep_pkg::split_bit];
          direction[e] <= reg_wdata[usb_ep_pkg::direction_bit];
          // Split forces the IN pipe on; else direction decides.
          ep_is_in[e] <= reg_wdata[usb_ep_pkg::split_bit] |
                         reg_wdata[usb_ep_pkg::direction_bit];
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          send_stall[e] <= 1'b0;
        end else if (wr_low && index_sel == e[1:0]) begin
          send_stall[e] <= reg_wdata[usb_ep_pkg::send_stall_bit];
        end
      end

      // Flags set by hardware win over a software clear in the same cycle.
      always_ff @(posedge mclk) begin
        if (rst) begin
          stall_sent[e] <= 1'b0;
          underflow[e] <= 1'b0;
        end else begin
          if (wr_low && index_sel == e[1:0]) begin
            stall_sent[e] <= reg_wdata[usb_ep_pkg::stall_sent_bit];
            underflow[e] <= reg_wdata[usb_ep_pkg::underflow_bit];
          end
          if (tok && send_stall[e]) begin
            stall_sent[e] <= 1'b1;
          end else if (tok && iso[e] && !has_pkt) begin
            underflow[e] <= 1'b1;
          end
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          stage[e] <= 1'b0;
          ready[e] <= 1'b0;
          pending[e] <= 1'b0;
          spare[e] <= 1'b0;
          empty_pkt[e] <= 1'b0;
          spare_empty[e] <= 1'b0;
          held[e] <= 1'b0;
        end else begin
          if (fifo_data_written[e]) begin
            stage[e] <= 1'b1;
          end
          if (ready_wr) begin
            ready[e] <= 1'b1;
          end
          if (sof_seen) begin
            held[e] <= 1'b0;
          end
          // A commit waits one cycle after a send, so that the two slots
          // never move in the same cycle.
          if (send) begin
            // The second slot, if full, moves up to be sent next.
            pending[e] <= spare[e];
            empty_pkt[e] <= spare_empty[e];
            spare[e] <= 1'b0;
            held[e] <= spare[e] && iso[e] && iso_update[e] && !sof_seen;
          end else if (ready[e] && !pending[e]) begin
            // A slot is open, so commit and free the ready flag.
            ready[e] <= 1'b0;
            pending[e] <= 1'b1;
            empty_pkt[e] <= !stage[e];
            stage[e] <= 1'b0;
            held[e] <= iso[e] && iso_update[e] && !sof_seen;
          end else if (ready[e] && double_buf[e] && !spare[e]) begin
            // Second slot frees the ready flag at once, with no event.
            ready[e] <= 1'b0;
            spare[e] <= 1'b1;
            spare_empty[e] <= !stage[e];
            stage[e] <= 1'b0;
          end
          if (flush_wr) begin
            pending[e] <= 1'b0;
            spare[e] <= 1'b0;
            ready[e] <= 1'b0;
            stage[e] <= 1'b0;
          end
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          toggle[e] <= 1'b0;
        end else if (wr_low && index_sel == e[1:0] &&
                     reg_wdata[usb_ep_pkg::toggle_reset_bit]) begin
          toggle[e] <= 1'b0;
        end else if ((force_toggle[e] && tok && !send_stall[e] && has_pkt) ||
                     (!force_toggle[e] && ack)) begin
          toggle[e] <= ~toggle[e];
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          event_flag[e] <= 1'b0;
        end else begin
          // Stall, delivery and non-empty flush raise the event.
          event_flag[e] <= (tok && send_stall[e]) ||
                           (send && (iso[e] || force_toggle[e])) ||
                           (ack && !iso[e] && !force_toggle[e]) ||
                           (flush_wr && fifo_not_empty[e]);
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          fifo_flush[e] <= 1'b0;
        end else begin
          fifo_flush[e] <= flush_wr;
        end
      end

      stall_ev_a: assert property (
        @(posedge mclk) disable iff (rst)
        tok && send_stall[e] |=> stall_sent[e] && event_flag[e])
        else $error("stall did not set its flag and event");
      iso_under_a: assert property (
        @(posedge mclk) disable iff (rst)
        tok && iso[e] && !send_stall[e] && !has_pkt |=> underflow[e])
        else $error("iso underflow not flagged");
      toggle_hold_a: assert property (
        @(posedge mclk) disable iff (rst)
        !force_toggle[e] && !ack && !wr_low |=> $stable(toggle[e]))
        else $error("toggle moved without ack");
      iso_hold_a: assert property (
        @(posedge mclk) disable iff (rst)
        held[e] && !sof_seen |=> !(tok && has_pkt))
        else $error("held iso packet left early");
      slot_commit_a: assert property (
        @(posedge mclk) disable iff (rst)
        ready[e] && !send && !pending[e] && !flush_wr
        |=> pending[e] && !ready[e])
        else $error("open slot did not take the ready packet");
      second_slot_a: assert property (
        @(posedge mclk) disable iff (rst)
        ready[e] && !send && pending[e] && double_buf[e] && !spare[e] &&
        !flush_wr |=> spare[e] && !ready[e])
        else $error("second slot did not take the ready packet");
      toggle_clear_a: assert property (
        @(posedge mclk) disable iff (rst)
        wr_low && index_sel == e[1:0] &&
        reg_wdata[usb_ep_pkg::toggle_reset_bit] |=> !toggle[e])
        else $error("toggle reset did not clear the toggle");
      ack_event_a: assert property (
        @(posedge mclk) disable iff (rst)
        ack && !iso[e] && !force_toggle[e] |=> event_flag[e])
        else $error("acknowledged packet raised no event");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // One answer per token to an enabled IN endpoint 1-3, chosen from its state.
  always_ff @(posedge mclk) begin
    if (rst) begin
      answer <= '0;
    end else begin
      answer <= '0;
      if (in_token.valid && in_token.ep != 2'd0 && ep_on[in_token.ep] &&
          ep_is_in[in_token.ep]) begin
        answer.valid <= 1'b1;
        answer.ep <= in_token.ep;
        answer.toggle <= toggle[in_token.ep];
        if (send_stall[in_token.ep]) begin
          answer.kind <= usb_ep_pkg::hs_stall;
        end else if (pending[in_token.ep] && !held[in_token.ep]) begin
          answer.kind <= usb_ep_pkg::hs_data;
          answer.zero_length <= empty_pkt[in_token.ep];
        end else if (iso[in_token.ep]) begin
          answer.kind <= usb_ep_pkg::hs_data;
          answer.zero_length <= 1'b1;
        end else begin
          answer.kind <= usb_ep_pkg::hs_nak;
        end
      end
    end
  end

  ep_off_a: assert property (
    @(posedge mclk) disable iff (rst)
    in_token.valid && in_token.ep != 2'd0 && !ep_on[in_token.ep]
    |=> !answer.valid)
    else $error("disabled endpoint answered");
  ep_answer_a: assert property (
    @(posedge mclk) disable iff (rst)
    in_token.valid && in_token.ep != 2'd0 && ep_on[in_token.ep] &&
    ep_is_in[in_token.ep]
    |=> answer.valid && answer.ep == $past(in_token.ep))
    else $error("enabled endpoint gave no answer");
  count_rd_a: assert property (
    @(posedge mclk) disable iff (rst)
    reg_read && reg_addr == usb_ep_pkg::endpoint0_rx_byte_count_addr
    |=> reg_rdata == {1'b0, $past(ep0_fifo_count)})
    else $error("count register readback wrong");
  enable_rd_a: assert property (
    @(posedge mclk) disable iff (rst)
    reg_read && reg_addr == usb_ep_pkg::endpoint_enable_bits_addr
    |=> reg_rdata[7:4] == 4'hf && reg_rdata[0])
    else $error("enable register fixed bits wrong");
  stall_ans_a: assert property (
    @(posedge mclk) disable iff (rst)
    answer.valid && answer.kind == usb_ep_pkg::hs_stall
    |-> stall_sent[answer.ep])
    else $error("stall answer without flag");

endmodule

// *** rtl/usb_ep_pkg.sv ***
// Purpose: Constants and carriers for the endpoint 0-3 management logic.
// Assumes: One clock, synchronous active-high reset, byte-wide registers.
// Notes: Register offsets are byte addresses on the plain register port.
//
// Overview of operation
// - Endpoint-0 count shows received byte count in bits 6:0, valid with out-ready.
// - Bit 7 of the endpoint-0 count reads zero; writes do nothing.
// - Only the selected endpoint's IN/OUT control group is visible at a time.
// - Split mode set gives the endpoint both an IN and an OUT pipe.
// - Split clear: direction choice makes the endpoint IN or OUT only.
// - Disabled endpoints 1-3 give no handshake at all; all enabled at reset.
// - Enable bits 7:4 read 1111b; software writes 1 to bit 0.
// - Enable bits 3..1 switch endpoints 3..1; 0 off, 1 normal.
// - IN endpoints do bulk, interrupt and iso; bulk and interrupt handled alike.
// - IN interrupt on delivery, flush of a non-empty FIFO, or a sent STALL.
// - Bulk: ready packet sent on the next IN token, ready cleared, interrupt.
// - Ready set with no data written sends a zero-length packet.
// - Send-stall answers every IN with STALL, sets stall-sent flag, interrupts.
// - Ready clears when a slot is free; double buffer frees it at once.
// - Force toggle flips the toggle every packet; otherwise only on ACK.
// - Iso IN with nothing ready sends zero-length data and sets underflow.
// - With iso update, a loaded packet waits until the next start of frame.
// - Writing 1 to toggle reset clears the data toggle; reads back as 0.
package usb_ep_pkg;
  localparam logic [7:0] index_select_addr = 8'h0e;
  localparam logic [7:0] in_ctrl_status_low_addr = 8'h11;
  localparam logic [7:0] in_ctrl_status_high_addr = 8'h12;
  localparam logic [7:0] out_ctrl_status_low_addr = 8'h14;
  localparam logic [7:0] out_ctrl_status_high_addr = 8'h15;
  localparam logic [7:0] endpoint0_rx_byte_count_addr = 8'h16;
  localparam logic [7:0] endpoint_enable_bits_addr = 8'h1e;
  localparam logic [7:0] in_event_addr = 8'h20;
  localparam logic [7:0] enable_reset = 8'hff;
  localparam logic [3:0] enable_high_ones = 4'hf;
  localparam int ready_bit = 0;
  localparam int underflow_bit = 2;
  localparam int flush_bit = 3;
  localparam int send_stall_bit = 4;
  localparam int stall_sent_bit = 5;
  localparam int toggle_reset_bit = 6;
  localparam int double_buffer_bit = 7;
  localparam int direction_bit = 2;
  localparam int force_toggle_bit = 3;
  localparam int split_bit = 4;
  localparam int iso_update_bit = 5;
  localparam int iso_bit = 6;

  typedef enum logic [1:0] {
    hs_none,
    hs_data,
    hs_stall,
    hs_nak
  } reply_type;

  typedef struct packed {
    logic valid;
    logic [1:0] ep;
  } token_type;

  typedef struct packed {
    logic valid;
    reply_type kind;
    logic [1:0] ep;
    logic zero_length;
    logic toggle;
  } answer_type;
endpackage

// *** test/usb_host_model.sv ***
// Purpose: Host side that issues IN tokens, ACKs and start-of-frame pulses.
// Assumes: Answers come the cycle after a token, as one-cycle pulses.
// Notes: Wire-level packets are not modelled; only the token-level handshake.
module usb_host_model (
  input wire logic mclk,
  input wire usb_ep_pkg::answer_type answer,
  output usb_ep_pkg::token_type in_token,
  output logic host_ack,
  output logic [1:0] ack_ep,
  output logic sof_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    in_token = '0;
    host_ack = 1'b0;
    ack_ep = 2'h0;
    sof_seen = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic in_request(input logic [1:0] ep, input logic ack,
      output usb_ep_pkg::answer_type got);
    @(posedge mclk);
    in_token <= '{valid: 1'b1, ep: ep};
    @(posedge mclk);
    // A released endpoint field shows a changed value, never the old one.
    in_token <= '{valid: 1'b0, ep: ~ep};
    @(negedge mclk);
    got = answer;
    // The host acknowledges only a data packet that it received.
    if (ack && got.valid && got.kind == usb_ep_pkg::hs_data) begin
      @(posedge mclk);
      host_ack <= 1'b1;
      ack_ep <= ep;
      @(posedge mclk);
      host_ack <= 1'b0;
      ack_ep <= ~ep;
    end
  endtask
  // Each frame opens with one start of frame; iso tokens follow singly.
  task automatic frame_start();
    @(posedge mclk);
    sof_seen <= 1'b1;
    @(posedge mclk);
    sof_seen <= 1'b0;
  endtask
endmodule

// *** test/test_usb_endpoint_in_control.sv ***
// Purpose: Self-checking bench for the endpoint IN control block.
// Assumes: The host model makes tokens; the bench owns registers and FIFOs.
// Notes: Outputs are judged at the falling edge, after updates have landed.
module test_usb_endpoint_in_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, reg_write, reg_read, out_packet_waiting, sof_seen;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
  logic [6:0] ep0_fifo_count;
  logic [3:1] fifo_data_written, fifo_not_empty, in_event, fifo_flush;
  logic [3:1] ep_split, ep_is_in;
  logic host_ack;
  logic [1:0] ack_ep;
  usb_ep_pkg::token_type in_token;
  usb_ep_pkg::answer_type answer;
  int err_total, comparisons;
  usb_endpoint_in_control DUT (.mclk, .rst, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .ep0_fifo_count, .out_packet_waiting,
    .fifo_data_written, .fifo_not_empty, .sof_seen, .in_token, .host_ack,
    .ack_ep, .answer, .in_event, .fifo_flush, .ep_split, .ep_is_in);
  usb_host_model host (.mclk, .answer, .in_token, .host_ack, .ack_ep,
    .sof_seen);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: read %h, expected %h", $time, g, e);
    end
  endtask
  task automatic chk_ans(input usb_ep_pkg::answer_type g, e, input logic tg);
    comparisons++;
    // A stall carries no meaningful toggle, so it can be left out.
    if (!tg)
      g.toggle = e.toggle;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: answer %h, expected %h", $time, g, e);
    end
  endtask
  function automatic usb_ep_pkg::answer_type mk(usb_ep_pkg::reply_type k,
      logic [1:0] ep, logic zl, logic tg);
    mk = '{valid: 1'b1, kind: k, ep: ep, zero_length: zl, toggle: tg};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(negedge mclk);
    chk8(reg_rdata, e);
  endtask
  task automatic wl(input logic [7:0] d);
    wr(usb_ep_pkg::in_ctrl_status_low_addr, d);
  endtask
  task automatic wh(input logic [7:0] d);
    wr(usb_ep_pkg::in_ctrl_status_high_addr, d);
  endtask
  task automatic req(input logic [1:0] ep, input logic ack,
      input usb_ep_pkg::answer_type e, input logic tg);
    usb_ep_pkg::answer_type a;
    host.in_request(ep, ack, a);
    chk_ans(a, e, tg);
  endtask
  task automatic evt(input int ep);
    for (int i = 0; i < 6 && in_event[ep] !== 1'b1; i++)
      @(negedge mclk);
    chk8({7'h0, in_event[ep]}, 8'h01);
  endtask
  task automatic load(input int ep);
    @(posedge mclk);
    fifo_data_written <= 3'h1 << (ep - 1);
    @(posedge mclk);
    fifo_data_written <= 3'h0;
  endtask
  task automatic done(input string s);
    $display("%s finished, %0d mismatches so far", s, err_total);
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rchk(usb_ep_pkg::endpoint0_rx_byte_count_addr, 8'h6b);
    wr(usb_ep_pkg::endpoint0_rx_byte_count_addr, 8'hff);
    rchk(usb_ep_pkg::endpoint0_rx_byte_count_addr, 8'h6b);
    rchk(usb_ep_pkg::endpoint_enable_bits_addr, 8'hff);
    rchk(8'h3f, 8'h00);
    wr(usb_ep_pkg::index_select_addr, 8'h01);
    wh(8'h04);
    wr(usb_ep_pkg::index_select_addr, 8'h02);
    rchk(usb_ep_pkg::in_ctrl_status_high_addr, 8'h00);
    wr(usb_ep_pkg::index_select_addr, 8'h01);
    rchk(usb_ep_pkg::in_ctrl_status_high_addr, 8'h04);
    chk8({5'h0, ep_is_in}, 8'h01);
    done("registers");
  endtask
  task automatic t_enable();
    wl(8'h01);
    rchk(usb_ep_pkg::in_ctrl_status_low_addr, 8'h00);
    wr(usb_ep_pkg::endpoint_enable_bits_addr, 8'hfd);
    rchk(usb_ep_pkg::endpoint_enable_bits_addr, 8'hfd);
    req(2'h1, 1'b0, '0, 1'b1);
    wr(usb_ep_pkg::endpoint_enable_bits_addr, 8'h01);
    rchk(usb_ep_pkg::endpoint_enable_bits_addr, 8'hf1);
    wr(usb_ep_pkg::endpoint_enable_bits_addr, 8'hff);
    req(2'h1, 1'b1, mk(usb_ep_pkg::hs_data, 2'h1, 1'b1, 1'b0), 1'b1);
    evt(1);
    done("enable");
  endtask
  task automatic t_bulk();
    load(1);
    wl(8'h01);
    req(2'h1, 1'b1, mk(usb_ep_pkg::hs_data, 2'h1, 1'b0, 1'b1), 1'b1);
    evt(1);
    wl(8'h10);
    req(2'h1, 1'b0, mk(usb_ep_pkg::hs_stall, 2'h1, 1'b0, 1'b0), 1'b0);
    evt(1);
    rchk(usb_ep_pkg::in_ctrl_status_low_addr, 8'h30);
    wl(8'h00);
    rchk(usb_ep_pkg::in_ctrl_status_low_addr, 8'h00);
    done("bulk");
  endtask
  task automatic t_toggle();
    wh(8'h0c);
    wl(8'h01);
    req(2'h1, 1'b1, mk(usb_ep_pkg::hs_data, 2'h1, 1'b1, 1'b0), 1'b1);
    wl(8'h01);
    req(2'h1, 1'b0, mk(usb_ep_pkg::hs_data, 2'h1, 1'b1, 1'b1), 1'b1);
    wl(8'h01);
    req(2'h1, 1'b0, mk(usb_ep_pkg::hs_data, 2'h1, 1'b1, 1'b0), 1'b1);
    wh(8'h04);
    wl(8'h40);
    rchk(usb_ep_pkg::in_ctrl_status_low_addr, 8'h00);
    wl(8'h01);
    req(2'h1, 1'b0, mk(usb_ep_pkg::hs_data, 2'h1, 1'b1, 1'b0), 1'b1);
    done("toggle");
  endtask
  task automatic t_double();
    wh(8'h84);
    load(1);
    wl(8'h01);
    load(1);
    wl(8'h01);
    wl(8'h01);
    rchk(usb_ep_pkg::in_ctrl_status_low_addr, 8'h01);
    req(2'h1, 1'b0, mk(usb_ep_pkg::hs_data, 2'h1, 1'b0, 1'b0), 1'b1);
    req(2'h1, 1'b0, mk(usb_ep_pkg::hs_data, 2'h1, 1'b0, 1'b0), 1'b1);
    req(2'h1, 1'b0, mk(usb_ep_pkg::hs_data, 2'h1, 1'b1, 1'b0), 1'b1);
    rchk(usb_ep_pkg::in_ctrl_status_low_addr, 8'h00);
    done("double buffer");
  endtask
  task automatic t_iso();
    wr(usb_ep_pkg::index_select_addr, 8'h02);
    wh(8'h44);
    host.frame_start();
    req(2'h2, 1'b0, mk(usb_ep_pkg::hs_data, 2'h2, 1'b1, 1'b0), 1'b0);
    rchk(usb_ep_pkg::in_ctrl_status_low_addr, 8'h04);
    wh(8'h64);
    wl(8'h00);
    host.frame_start();
    load(2);
    wl(8'h01);
    req(2'h2, 1'b0, mk(usb_ep_pkg::hs_data, 2'h2, 1'b1, 1'b0), 1'b0);
    host.frame_start();
    req(2'h2, 1'b0, mk(usb_ep_pkg::hs_data, 2'h2, 1'b0, 1'b0), 1'b0);
    done("isochronous");
  endtask
  task automatic t_flush();
    wr(usb_ep_pkg::index_select_addr, 8'h03);
    wh(8'h10);
    @(negedge mclk);
    chk8({7'h0, ep_is_in[3]}, 8'h01);
    chk8({5'h0, ep_split}, 8'h04);
    @(posedge mclk);
    fifo_not_empty <= 3'h4;
    wl(8'h08);
    @(negedge mclk);
    chk8({5'h0, fifo_flush}, 8'h04);
    evt(3);
    @(posedge mclk);
    fifo_not_empty <= 3'h0;
    done("flush");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    comparisons = 0;
    rst = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ep0_fifo_count = 7'h6b;
    out_packet_waiting = 1'b1;
    fifo_data_written = 3'h0;
    fifo_not_empty = 3'h0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_enable();
    t_bulk();
    t_toggle();
    t_double();
    t_iso();
    t_flush();
    conclude();
  end
endmodule
